/* common/lpsdram_port_pkg.sv */
/*
 * constants and types for the low-power SDRAM command and lane port.
 * assumes a single system clock; the memory clock arrives as a pin and is
 * sampled by the system clock.
 */
// Operation
// - sample strobes, selects, bank, address, clock enable at memory clock rise
// - die select low means the die is addressed and takes the command
// - die select high: command ignored, running operation carries on
// - mask bit high: write byte not stored, read byte suppressed
// - mask bit one covers upper byte, bit zero covers lower byte
// - strobes driven by device on reads, by controller on writes
// - strobe one times upper byte, strobe zero times lower byte
// - clock enable low makes the next edge invalid and suspends the die
// - two-bit bank select picks one of four banks per command
package lpsdram_port_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int BANKS = 4;
	localparam int DIES = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int WORD_W = DATA_W + LANES;
	localparam int CMD_W = 3 + 2 + ADDR_W + 1;

	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACTIVATE = 3'h1,
		CMD_READ = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_PRECHARGE = 3'h4,
		CMD_REFRESH = 3'h5,
		CMD_MODE = 3'h6,
		CMD_BURST_STOP = 3'h7
	} cmd_t;
endpackage

/* hdl/lane_fifo.sv */
/*
 * small synchronous fifo with valid and ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module lane_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0] count_ff, nxt_count;
	logic push, pop;

	assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_ff[rd_ptr_ff];

	always_comb begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count = count_ff;
		if (push) begin
			nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
	end

	// storage has no reset; only pointers and count are control state
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end
endmodule
`default_nettype wire

/* hdl/lpsdram_command_and_lane_port.sv */
/*
 * command capture and byte-lane qualification for one low-power SDRAM die
 * slot pair. holds pin synchronisers, memory clock edge finder, command
 * decode, bank tracking shared by both dies, write lane fifo and read lane drive.
 * assumes the memory clock is much slower than sys_clk_i (160 ns against
 * 20 ns), so each memory clock half period spans several system cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module lpsdram_command_and_lane_port
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic mem_clk_i,
	input wire logic clk_en_i,
	input wire logic [lpsdram_port_pkg::DIES-1:0] die_sel_n_i,
	input wire logic row_strobe_n_i,
	input wire logic col_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic [1:0] bank_i,
	input wire logic [lpsdram_port_pkg::ADDR_W-1:0] addr_i,
	input wire logic [lpsdram_port_pkg::LANES-1:0] lane_mask_i,
	input wire logic [lpsdram_port_pkg::DATA_W-1:0] dq_i,
	output logic [lpsdram_port_pkg::DATA_W-1:0] dq_o,
	output logic [lpsdram_port_pkg::LANES-1:0] dq_oe_o,
	input wire logic upper_lane_strobe_i,
	output logic upper_lane_strobe_o,
	output logic upper_lane_strobe_oe_o,
	input wire logic lower_lane_strobe_i,
	output logic lower_lane_strobe_o,
	output logic lower_lane_strobe_oe_o,
	output logic cmd_valid_o,
	output lpsdram_port_pkg::cmd_t cmd_o,
	output logic [lpsdram_port_pkg::DIES-1:0] cmd_die_o,
	output logic [1:0] cmd_bank_o,
	output logic [lpsdram_port_pkg::ADDR_W-1:0] cmd_addr_o,
	output logic [lpsdram_port_pkg::BANKS-1:0] bank_open_o,
	output logic suspended_o,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [lpsdram_port_pkg::DATA_W-1:0] wr_data_o,
	output logic [lpsdram_port_pkg::LANES-1:0] wr_lane_en_o,
	output logic wr_overflow_o,
	input wire logic rd_valid_i,
	input wire logic [lpsdram_port_pkg::DATA_W-1:0] rd_data_i
);
	import lpsdram_port_pkg::*;
	default clocking chk_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	//==========================================================
	// pin synchronisers
	//==========================================================
	localparam int SYNC_W = 1 + 1 + DIES + 3 + 2 + ADDR_W + LANES + DATA_W + 2;
	logic [SYNC_W-1:0] pin_raw, meta_ff, pin_ff;
	assign pin_raw = {mem_clk_i, clk_en_i, die_sel_n_i, row_strobe_n_i,
		col_strobe_n_i, write_strobe_n_i, bank_i, addr_i, lane_mask_i, dq_i,
		upper_lane_strobe_i, lower_lane_strobe_i};
	logic s_clk, s_cke, s_ras_n, s_cas_n, s_we_n, s_ustb, s_lstb;
	logic [DIES-1:0] s_sel_n;
	logic [1:0] s_bank;
	logic [ADDR_W-1:0] s_addr;
	logic [LANES-1:0] s_mask;
	logic [DATA_W-1:0] s_dq;
	assign {s_clk, s_cke, s_sel_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr,
		s_mask, s_dq, s_ustb, s_lstb} = pin_ff;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_ff <= '0;
			pin_ff <= '0;
		end else begin
			meta_ff <= pin_raw;
			pin_ff <= meta_ff;
		end
	end

	//==========================================================
	// memory clock edge finder and clock enable
	//==========================================================
	logic clk_d_ff, cke_d_ff, nxt_cke, mem_rise, edge_ok;
	logic [LANES-1:0] stb_d_ff, stb_rise;
	assign mem_rise = s_clk && !clk_d_ff;
	// clock enable seen at the previous edge qualifies this one
	assign edge_ok = mem_rise && cke_d_ff;
	assign stb_rise = {s_ustb, s_lstb} & ~stb_d_ff;
	assign nxt_cke = mem_rise ? s_cke : cke_d_ff;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_d_ff <= 1'b0;
			cke_d_ff <= 1'b0;
			stb_d_ff <= '0;
		end else begin
			clk_d_ff <= s_clk;
			cke_d_ff <= nxt_cke;
			stb_d_ff <= {s_ustb, s_lstb};
		end
	end
	assign suspended_o = !cke_d_ff;
	//==========================================================
	// command decode
	//==========================================================
	cmd_t nxt_cmd, cmd_ff;
	logic nxt_cmd_valid, cmd_valid_ff;
	logic [DIES-1:0] nxt_die, die_ff;
	logic [1:0] nxt_cbank, cbank_ff;
	logic [ADDR_W-1:0] nxt_caddr, caddr_ff;
	cmd_t decoded;
	always_comb begin
		// customary low-power SDRAM truth table on row, column, write
		unique case ({s_ras_n, s_cas_n, s_we_n})
			3'h7: decoded = CMD_NOP;
			3'h3: decoded = CMD_ACTIVATE;
			3'h5: decoded = CMD_READ;
			3'h4: decoded = CMD_WRITE;
			3'h2: decoded = CMD_PRECHARGE;
			3'h1: decoded = CMD_REFRESH;
			3'h0: decoded = CMD_MODE;
			3'h6: decoded = CMD_BURST_STOP;
		endcase
	end
	always_comb begin
		nxt_cmd_valid = 1'b0;
		nxt_cmd = cmd_ff;
		nxt_die = die_ff;
		nxt_cbank = cbank_ff;
		nxt_caddr = caddr_ff;
		// bit one selects die two, bit zero die one; unused select is inert
		if (edge_ok && (s_sel_n != {DIES{1'b1}})) begin
			nxt_cmd_valid = (decoded != CMD_NOP);
			nxt_cmd = decoded;
			nxt_die = ~s_sel_n;
			nxt_cbank = s_bank;
			nxt_caddr = s_addr;
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_valid_ff <= 1'b0;
			cmd_ff <= CMD_NOP;
			die_ff <= '0;
			cbank_ff <= '0;
			caddr_ff <= '0;
		end else begin
			cmd_valid_ff <= nxt_cmd_valid;
			cmd_ff <= nxt_cmd;
			die_ff <= nxt_die;
			cbank_ff <= nxt_cbank;
			caddr_ff <= nxt_caddr;
		end
	end
	assign cmd_valid_o = cmd_valid_ff;
	assign cmd_o = cmd_ff;
	assign cmd_die_o = die_ff;
	assign cmd_bank_o = cbank_ff;
	assign cmd_addr_o = caddr_ff;

	//==========================================================
	// open bank tracking; in-flight state survives deselect
	//==========================================================
	logic [BANKS-1:0] open_ff, nxt_open;
	always_comb begin
		nxt_open = open_ff;
		if (cmd_valid_ff) begin
			unique case (cmd_ff)
				CMD_ACTIVATE: nxt_open[cbank_ff] = 1'b1;
				CMD_PRECHARGE: begin
					// address bit ten set means all banks
					if (caddr_ff[10]) begin
						nxt_open = '0;
					end else begin
						nxt_open[cbank_ff] = 1'b0;
					end
				end
				CMD_REFRESH, CMD_MODE: nxt_open = '0;
				default: nxt_open = open_ff;
			endcase
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			open_ff <= '0;
		end else begin
			open_ff <= nxt_open;
		end
	end
	assign bank_open_o = open_ff;

	//==========================================================
	// transfer direction
	//==========================================================
	logic wr_mode_ff, nxt_wr_mode, rd_mode_ff, nxt_rd_mode;
	always_comb begin
		nxt_wr_mode = wr_mode_ff;
		nxt_rd_mode = rd_mode_ff;
		if (cmd_valid_ff) begin
			nxt_wr_mode = (cmd_ff == CMD_WRITE);
			nxt_rd_mode = (cmd_ff == CMD_READ);
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_mode_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
		end else begin
			wr_mode_ff <= nxt_wr_mode;
			rd_mode_ff <= nxt_rd_mode;
		end
	end

	//==========================================================
	// write lanes: strobe edge captures its own byte and mask
	//==========================================================
	logic [DATA_W-1:0] wbuf_ff, nxt_wbuf;
	logic [LANES-1:0] wen_ff, nxt_wen, got_ff, nxt_got;
	logic push_ff, nxt_push, ovf_ff, nxt_ovf, fifo_in_ready;
	logic [WORD_W-1:0] fifo_out;
	always_comb begin
		nxt_wbuf = wbuf_ff;
		nxt_wen = wen_ff;
		nxt_got = push_ff ? '0 : got_ff;
		nxt_push = 1'b0;
		nxt_ovf = ovf_ff;
		for (int l = 0; l < LANES; l++) begin
			// strobe l times byte l; mask l kills that byte only
			if (wr_mode_ff && stb_rise[l]) begin
				nxt_wbuf[l*LANE_W +: LANE_W] = s_dq[l*LANE_W +: LANE_W];
				nxt_wen[l] = !s_mask[l];
				nxt_got[l] = 1'b1;
			end
		end
		if (nxt_got == {LANES{1'b1}} && !push_ff) begin
			nxt_push = 1'b1;
		end
		// the pins cannot be stalled, so a full fifo drops and flags
		if (push_ff && !fifo_in_ready) begin
			nxt_ovf = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wbuf_ff <= '0;
			wen_ff <= '0;
			got_ff <= '0;
			push_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end else begin
			wbuf_ff <= nxt_wbuf;
			wen_ff <= nxt_wen;
			got_ff <= nxt_got;
			push_ff <= nxt_push;
			ovf_ff <= nxt_ovf;
		end
	end
	assign wr_overflow_o = ovf_ff;

	lane_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(push_ff),
		.in_ready_o(fifo_in_ready),
		.in_data_i({wen_ff, wbuf_ff}),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(fifo_out)
	);
	assign {wr_lane_en_o, wr_data_o} = fifo_out;

	//==========================================================
	// read lanes: device drives strobes and unmasked bytes
	//==========================================================
	logic [DATA_W-1:0] dq_ff, nxt_dq;
	logic [LANES-1:0] dq_oe_ff, nxt_dq_oe;
	logic stb_oe_ff, nxt_stb_oe, stb_ff, nxt_stb;
	always_comb begin
		nxt_dq = dq_ff;
		nxt_dq_oe = '0;
		nxt_stb_oe = rd_mode_ff && rd_valid_i;
		nxt_stb = nxt_stb_oe && s_clk;
		if (rd_mode_ff && rd_valid_i) begin
			nxt_dq = rd_data_i;
			nxt_dq_oe = ~s_mask;
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dq_ff <= '0;
			dq_oe_ff <= '0;
			stb_oe_ff <= 1'b0;
			stb_ff <= 1'b0;
		end else begin
			dq_ff <= nxt_dq;
			dq_oe_ff <= nxt_dq_oe;
			stb_oe_ff <= nxt_stb_oe;
			stb_ff <= nxt_stb;
		end
	end
	assign dq_o = dq_ff;
	assign dq_oe_o = dq_oe_ff;
	// both strobes share one timing; each still belongs to its own byte
	assign upper_lane_strobe_o = stb_ff;
	assign lower_lane_strobe_o = stb_ff;
	assign upper_lane_strobe_oe_o = stb_oe_ff;
	assign lower_lane_strobe_oe_o = stb_oe_ff;

	//==========================================================
	// checks
	//==========================================================
	chk_deselect_ignored: assert property (
		(s_sel_n == {DIES{1'b1}}) |=> !cmd_valid_ff)
		else $error("command taken while deselected");
	chk_suspend_ignored: assert property (
		(mem_rise && !cke_d_ff) |=> !cmd_valid_ff)
		else $error("command taken on invalid edge");
	chk_cmd_on_edge: assert property (cmd_valid_ff |-> $past(edge_ok))
		else $error("command without qualified edge");
	chk_select_die: assert property (
		nxt_cmd_valid |=> (die_ff == ~$past(s_sel_n)))
		else $error("wrong die recorded");
	chk_bank_taken: assert property (
		nxt_cmd_valid |=> (cbank_ff == $past(s_bank)))
		else $error("bank select not captured");
	chk_activate_opens: assert property (
		(cmd_valid_ff && cmd_ff == CMD_ACTIVATE) |=> open_ff[$past(cbank_ff)])
		else $error("activate did not open bank");
	chk_read_mask: assert property (
		(rd_mode_ff && rd_valid_i) |=> (dq_oe_ff == ~$past(s_mask)))
		else $error("masked read byte driven");
	chk_write_mask: assert property (
		(wr_mode_ff && stb_rise[1]) |=> (wen_ff[1] == !$past(s_mask[1])))
		else $error("upper write mask wrong");
	chk_strobe_dir: assert property (stb_oe_ff |-> $past(rd_mode_ff))
		else $error("strobe driven outside read");
endmodule
`default_nettype wire

/* sim/mem_ctrl_model.sv */
/*
 * memory controller model: command pins, memory clock, write strobes.
 * assumes one bench process calls its tasks; clock stands still between.
 */
`timescale 1ns/1ns
`default_nettype none
module mem_ctrl_model
	import lpsdram_port_pkg::*;
(
	input wire logic sys_clk_i,
	output logic mem_clk_o,
	output logic clk_en_o,
	output logic [lpsdram_port_pkg::DIES-1:0] die_sel_n_o,
	output logic row_strobe_n_o,
	output logic col_strobe_n_o,
	output logic write_strobe_n_o,
	output logic [1:0] bank_o,
	output logic [lpsdram_port_pkg::ADDR_W-1:0] addr_o,
	output logic [lpsdram_port_pkg::LANES-1:0] lane_mask_o,
	output logic [lpsdram_port_pkg::DATA_W-1:0] dq_o,
	output logic upper_lane_strobe_o,
	output logic lower_lane_strobe_o
);
	initial begin
		mem_clk_o = 1'b0;
		clk_en_o = 1'b1;
		die_sel_n_o = 2'h3;
		{row_strobe_n_o, col_strobe_n_o, write_strobe_n_o} = 3'h7;
		bank_o = 2'h0;
		addr_o = '0;
		lane_mask_o = 2'h0;
		dq_o = '0;
		upper_lane_strobe_o = 1'b0;
		lower_lane_strobe_o = 1'b0;
	end
	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic set_mask(input logic [1:0] m);
		@(posedge sys_clk_i);
		lane_mask_o <= m;
	endtask
	// ==========================================================
	// one memory clock period carrying a single command
	task automatic cmd(input logic cke, input logic [1:0] sel,
		input logic [2:0] code, input logic [1:0] bank,
		input logic [12:0] addr);
		@(posedge sys_clk_i);
		clk_en_o <= cke;
		die_sel_n_o <= sel;
		{row_strobe_n_o, col_strobe_n_o, write_strobe_n_o} <= code;
		bank_o <= bank;
		addr_o <= addr;
		cycles(4);
		mem_clk_o <= 1'b1;
		cycles(4);
		mem_clk_o <= 1'b0;
		// selects and strobes idle, bank and address inverted so a late sample cannot match by luck
		die_sel_n_o <= 2'h3;
		{row_strobe_n_o, col_strobe_n_o, write_strobe_n_o} <= 3'h7;
		bank_o <= ~bank;
		addr_o <= ~addr;
	endtask
	// ==========================================================
	// lanes strobed one after the other; the other byte is wrong then
	task automatic wr_word(input logic [15:0] d, input logic [1:0] m);
		@(posedge sys_clk_i);
		lane_mask_o <= m;
		dq_o <= {~d[15:8], d[7:0]};
		cycles(4);
		lower_lane_strobe_o <= 1'b1;
		cycles(4);
		dq_o <= {d[15:8], ~d[7:0]};
		cycles(4);
		upper_lane_strobe_o <= 1'b1;
		cycles(4);
		lower_lane_strobe_o <= 1'b0;
		upper_lane_strobe_o <= 1'b0;
		dq_o <= ~d;
		cycles(2);
	endtask
endmodule
`default_nettype wire

/* sim/lpsdram_command_and_lane_port_tb.sv */
/*
 * self-checking bench for the command and lane port.
 * assumes the controller model drives every memory pin.
 */
`timescale 1ns/1ns
`default_nettype none
module lpsdram_command_and_lane_port_tb;
	import lpsdram_port_pkg::*;
	logic sys_clk, nrst_n, wr_ready, rd_valid;
	logic [15:0] rd_data;
	wire logic mem_clk, cke, ras_n, cas_n, we_n, us_m, ls_m, us_d, ls_d;
	wire logic us_oe, ls_oe, cmd_valid, suspended, wr_valid, wr_ovf;
	wire logic [1:0] sel_n, bank, mask, dq_oe, cmd_die, cmd_bank, lane_en;
	wire logic [12:0] addr, cmd_addr;
	wire logic [15:0] dq_m, dq_d, wr_data;
	wire logic [3:0] bank_open;
	wire logic [2:0] cmd;
	int error_cnt = 0;
	int check_count = 0;
	int pulse_cnt = 0;
	logic [2:0] codes [7] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
	cmd_t kinds [7] = '{CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
		CMD_REFRESH, CMD_MODE, CMD_BURST_STOP};
	// strobe wires resolved from both drivers
	wire logic us_w = us_oe ? us_d : us_m;
	wire logic ls_w = ls_oe ? ls_d : ls_m;
	mem_ctrl_model i_ctrl (.sys_clk_i(sys_clk), .mem_clk_o(mem_clk),
		.clk_en_o(cke), .die_sel_n_o(sel_n), .row_strobe_n_o(ras_n),
		.col_strobe_n_o(cas_n), .write_strobe_n_o(we_n), .bank_o(bank),
		.addr_o(addr), .lane_mask_o(mask), .dq_o(dq_m),
		.upper_lane_strobe_o(us_m), .lower_lane_strobe_o(ls_m));
	lpsdram_command_and_lane_port i_dut (.sys_clk_i(sys_clk),
		.nrst_i(nrst_n), .mem_clk_i(mem_clk), .clk_en_i(cke),
		.die_sel_n_i(sel_n), .row_strobe_n_i(ras_n), .col_strobe_n_i(cas_n),
		.write_strobe_n_i(we_n), .bank_i(bank), .addr_i(addr),
		.lane_mask_i(mask), .dq_i(dq_m), .dq_o(dq_d), .dq_oe_o(dq_oe),
		.upper_lane_strobe_i(us_w), .upper_lane_strobe_o(us_d),
		.upper_lane_strobe_oe_o(us_oe), .lower_lane_strobe_i(ls_w),
		.lower_lane_strobe_o(ls_d), .lower_lane_strobe_oe_o(ls_oe),
		.cmd_valid_o(cmd_valid), .cmd_o(cmd), .cmd_die_o(cmd_die),
		.cmd_bank_o(cmd_bank), .cmd_addr_o(cmd_addr),
		.bank_open_o(bank_open), .suspended_o(suspended),
		.wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_data_o(wr_data),
		.wr_lane_en_o(lane_en), .wr_overflow_o(wr_ovf),
		.rd_valid_i(rd_valid), .rd_data_i(rd_data));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (cmd_valid === 1'b1) begin
			pulse_cnt++;
		end
	end
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========================================================
	// one command, then the count of decoded pulses it raised
	task automatic send(input logic cke_v, input logic [1:0] sel,
		input logic [2:0] code, input logic [1:0] b, input logic [12:0] a,
		input int exp_n);
		pulse_cnt = 0;
		i_ctrl.cmd(cke_v, sel, code, b, a);
		repeat (4) @(posedge sys_clk);
		chk("pulses", pulse_cnt, exp_n);
	endtask
	task automatic t_reset();
		chk("suspended", suspended, 1'b1);
		chk("cmd_valid", cmd_valid, 1'b0);
		chk("dq_oe", dq_oe, 2'h0);
		chk("strobe_oe", {us_oe, ls_oe}, 2'h0);
		chk("wr_valid", wr_valid, 1'b0);
		chk("bank_open", bank_open, 4'h0);
	endtask
	task automatic t_cmds();
		send(1'b1, 2'h3, 3'h7, 2'h0, 13'h0000, 0);
		chk("awake", suspended, 1'b0);
		for (int i = 0; i < 7; i++) begin
			send(1'b1, 2'h2, codes[i], i[1:0], 13'h1555 ^ i[12:0], 1);
			chk("cmd", cmd, kinds[i]);
			chk("die", cmd_die, 2'h1);
			chk("bank", cmd_bank, i[1:0]);
			chk("addr", cmd_addr, 13'h1555 ^ i[12:0]);
		end
	endtask
	task automatic t_banks();
		send(1'b1, 2'h2, 3'h3, 2'h1, 13'h0000, 1);
		send(1'b1, 2'h1, 3'h3, 2'h3, 13'h0000, 1);
		chk("open", bank_open, 4'hA);
		send(1'b1, 2'h2, 3'h2, 2'h1, 13'h0000, 1);
		chk("one_shut", bank_open, 4'h8);
		send(1'b1, 2'h2, 3'h2, 2'h0, 13'h0400, 1);
		chk("all_shut", bank_open, 4'h0);
	endtask
	task automatic t_select();
		send(1'b1, 2'h3, 3'h1, 2'h0, 13'h0000, 0);
		send(1'b1, 2'h1, 3'h1, 2'h2, 13'h0000, 1);
		chk("die_two", cmd_die, 2'h2);
		send(1'b1, 2'h0, 3'h1, 2'h0, 13'h0000, 1);
		chk("both", cmd_die, 2'h3);
	endtask
	task automatic t_cke();
		send(1'b0, 2'h3, 3'h7, 2'h0, 13'h0000, 0);
		chk("susp", suspended, 1'b1);
		send(1'b1, 2'h2, 3'h1, 2'h0, 13'h0000, 0);
		send(1'b1, 2'h2, 3'h1, 2'h0, 13'h0000, 1);
		chk("resumed", suspended, 1'b0);
	endtask
	// ==========================================================
	// nine words into a stalled fifo of eight: the last one is dropped
	task automatic t_write();
		int n;
		send(1'b1, 2'h2, 3'h4, 2'h0, 13'h0000, 1);
		for (int i = 0; i < 9; i++) begin
			i_ctrl.wr_word(16'h1E0F + 16'h0101 * i[15:0], i[1:0]);
			chk("strobe_oe_wr", {us_oe, ls_oe}, 2'h0);
		end
		chk("overflow", wr_ovf, 1'b1);
		for (int i = 0; i < 8; i++) begin
			n = 0;
			while (wr_valid !== 1'b1 && n < 50) begin
				@(posedge sys_clk);
				n++;
			end
			chk("wr_valid", wr_valid, 1'b1);
			chk("wr_data", wr_data, 16'h1E0F + 16'h0101 * i[15:0]);
			chk("lane_en", lane_en, {30'h0, ~i[1:0]});
			wr_ready <= 1'b1;
			@(posedge sys_clk);
			wr_ready <= 1'b0;
			@(posedge sys_clk);
		end
		chk("drained", wr_valid, 1'b0);
	endtask
	task automatic t_read();
		send(1'b1, 2'h2, 3'h5, 2'h0, 13'h0000, 1);
		i_ctrl.set_mask(2'h2);
		rd_data <= 16'h3CC3;
		rd_valid <= 1'b1;
		i_ctrl.cmd(1'b1, 2'h3, 3'h7, 2'h0, 13'h0000);
		chk("rd_oe", dq_oe, 2'h1);
		chk("rd_low", dq_d[7:0], 8'hC3);
		chk("rd_strobe", ls_oe, 1'b1);
		chk("rd_strobe_oe", {us_oe, ls_oe}, 2'h3);
		chk("rd_strobe_hi", {us_d, ls_d}, 2'h3);
		repeat (4) @(posedge sys_clk);
		chk("rd_strobe_lo", {us_d, ls_d, us_oe, ls_oe}, 4'h3);
		rd_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("rd_release", {us_oe, ls_oe, dq_oe}, 4'h0);
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		test_done();
	end
	initial begin
		nrst_n = 1'b0;
		wr_ready = 1'b0;
		rd_valid = 1'b0;
		rd_data = 16'h0000;
		repeat (2) @(posedge sys_clk);
		nrst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_cmds();
		t_banks();
		t_select();
		t_cke();
		t_write();
		t_read();
		test_done();
	end
endmodule
`default_nettype wire
